// [core/wtc_core.sv]
`timescale 1ns/10ps
`default_nettype none
// Function
// - In mode 01 the software enable alone runs or stops the watchdog, asleep or awake.
// - Mode 11 always runs, mode 10 runs only while awake, mode 00 never runs.
// - Period select code n gives a ratio of 2^(n+5), from 1:32 at 00000 to 1:8388608.
// - Period select codes 10011 to 11111 behave as the 1:32 ratio.
// - Any reset puts the period select back to 01011.
// - The count is cleared by reset, clear pulse, sleep entry and exit, osc fail, disable, ost.
// - Entering sleep with the watchdog active clears the count, which then runs again.
// - Leaving sleep on a crystal clock holds the count clear until the ost is done.
// - A time-out in sleep wakes the core instead of resetting and updates both flags.
// - Changing the rc divider selection leaves the count alone.
// - The software enable is heeded only in mode 01 and ignored otherwise.
// - Control holds period select in bits 5..1, enable in bit 0, bits 7..6 read zero.
// - Active and awake, a missed clear within the period raises a system reset.
// - The time base is the 31 kHz rc tick, not the system clock.
module wtc_core #(
  parameter logic [wtc_pkg::DIV_W-1:0] TICK_CYCLES = wtc_pkg::TICK_CYCLES_DEF
) (
  input  wire logic                        mclk_in,
  input  wire logic                        rst_n_in,
  input  wire logic [wtc_pkg::ADDR_W-1:0]  addr_in,
  input  wire logic [wtc_pkg::DATA_W-1:0]  wdata_in,
  input  wire logic                        wr_in,
  input  wire logic                        rd_in,
  output logic      [wtc_pkg::DATA_W-1:0]  rdata_out,
  input  wire logic [1:0]                  watchdog_config_mode_in,
  input  wire logic                        sleep_in,
  input  wire logic                        clear_watchdog_instr_in,
  input  wire logic                        osc_fail_in,
  input  wire logic                        osc_startup_timer_in,
  input  wire logic                        crystal_clock_in,
  output logic                             wdt_reset_out,
  output logic                             wake_out,
  output logic                             watchdog_expired_flag_out,
  output logic                             sleep_entered_flag_out,
  output logic                             irq_out
);
  import wtc_pkg::*;

  logic [PS_W-1:0]    period_select;
  logic               sw_watchdog_enable;
  logic [CNT_W-1:0]   wdt_count;
  logic [CNT_W-1:0]   terminal;
  logic [PS_W-1:0]    eff_ps;
  logic               tick;
  logic               active;
  logic               sleep_q;
  logic               sleep_rise;
  logic               sleep_fall;
  logic               exit_hold;
  logic               clear_cond;
  logic               timeout;
  logic [IRQ_N-1:0]   irq_events;
  logic [IRQ_N-1:0]   irq_status;
  logic [IRQ_N-1:0]   irq_enable;
  logic [DATA_W-1:0]  next_rdata;

  // rc time base, its own counter so divider selection elsewhere is moot
  wtc_tick_div #(
    .DIV_W  (DIV_W),
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .tick_out (tick)
  );

  // run decision from the mode straps and the software bit
  always_comb begin
    case (watchdog_config_mode_in)
      MODE_ALWAYS_ON:  active = 1'b1;
      MODE_OFF_SLEEP:  active = !sleep_in;
      MODE_SOFTWARE:   active = sw_watchdog_enable;
      MODE_ALWAYS_OFF: active = 1'b0;
      default:         active = 1'b0;
    endcase
  end

  // ratio 2^(code+5); reserved codes fall back to the shortest
  always_comb begin
    eff_ps   = (period_select > PS_MAX) ? '0 : period_select;
    terminal = (CNT_W'(1) << (eff_ps + PS_BASE_SHIFT)) - CNT_W'(1);
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      sleep_q <= 1'b0;
    end else begin
      sleep_q <= sleep_in;
    end
  end

  assign sleep_rise = sleep_in && !sleep_q;
  assign sleep_fall = !sleep_in && sleep_q;

  // crystal clocks keep the count clear past exit until ost ends
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      exit_hold <= 1'b0;
    end else if (sleep_fall && crystal_clock_in) begin
      exit_hold <= 1'b1;
    end else if (!osc_startup_timer_in) begin
      exit_hold <= 1'b0;
    end
  end

  assign clear_cond = clear_watchdog_instr_in || osc_fail_in || osc_startup_timer_in
                   || exit_hold || sleep_rise || sleep_fall || !active;
  assign timeout = active && tick && (wdt_count == terminal) && !clear_cond;

  // only tick and clear sources move the count, no divider input exists
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in || clear_cond) begin
      wdt_count <= '0;
    end else if (active && tick) begin
      if (wdt_count == terminal) begin
        wdt_count <= '0;
      end else begin
        wdt_count <= wdt_count + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      wdt_reset_out <= 1'b0;
      wake_out      <= 1'b0;
    end else begin
      wdt_reset_out <= timeout && !sleep_in;
      wake_out      <= timeout && sleep_in;
    end
  end

  // status flags: time-out sets expired, sleep entry sets slept, clear pulse drops both
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      watchdog_expired_flag_out <= 1'b0;
    end else if (timeout) begin
      watchdog_expired_flag_out <= 1'b1;
    end else if (clear_watchdog_instr_in || sleep_rise) begin
      watchdog_expired_flag_out <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      sleep_entered_flag_out <= 1'b0;
    end else if (sleep_rise || (timeout && sleep_in)) begin
      sleep_entered_flag_out <= 1'b1;
    end else if (clear_watchdog_instr_in) begin
      sleep_entered_flag_out <= 1'b0;
    end
  end

  // control register, reset value on every reset
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      period_select      <= PS_RESET;
      sw_watchdog_enable <= SWEN_RESET;
    end else if (wr_in && addr_in == OFF_CONTROL) begin
      period_select      <= wdata_in[PS_MSB:PS_LSB];
      sw_watchdog_enable <= wdata_in[SWEN_BIT];
    end
  end

  assign irq_events = {osc_fail_in, timeout && sleep_in, timeout && !sleep_in};

  wtc_irq_bank #(
    .N (IRQ_N)
  ) u_irq (
    .mclk_in      (mclk_in),
    .rst_n_in     (rst_n_in),
    .event_in     (irq_events),
    .enable_wr_in (wr_in && addr_in == OFF_IRQ_ENABLE),
    .clear_wr_in  (wr_in && addr_in == OFF_IRQ_CLEAR),
    .wdata_in     (wdata_in[IRQ_N-1:0]),
    .status_out   (irq_status),
    .enable_out   (irq_enable),
    .irq_out      (irq_out)
  );

  // unmapped and write-only offsets read zero
  always_comb begin
    next_rdata = '0;
    case (addr_in)
      OFF_CONTROL: begin
        next_rdata[PS_MSB:PS_LSB] = period_select;
        next_rdata[SWEN_BIT]      = sw_watchdog_enable;
      end
      OFF_IRQ_STATUS: next_rdata[IRQ_N-1:0] = irq_status;
      OFF_IRQ_ENABLE: next_rdata[IRQ_N-1:0] = irq_enable;
      OFF_STATE: begin
        next_rdata[ST_EXPIRED] = watchdog_expired_flag_out;
        next_rdata[ST_SLEPT]   = sleep_entered_flag_out;
        next_rdata[ST_ACTIVE]  = active;
        next_rdata[ST_HOLD]    = exit_hold;
      end
      default: next_rdata = '0;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      rdata_out <= '0;
    end else if (rd_in) begin
      rdata_out <= next_rdata;
    end else begin
      rdata_out <= '0;
    end
  end

  property p_sw_mode;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (watchdog_config_mode_in == MODE_SOFTWARE && !sw_watchdog_enable)
      |=> (wdt_count == '0) && !wdt_reset_out && !wake_out;
  endproperty
  a_sw_mode: assert property (p_sw_mode)
    else $error("software mode does not follow enable bit");

  property p_off_modes;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (watchdog_config_mode_in == MODE_ALWAYS_OFF
       || (watchdog_config_mode_in == MODE_OFF_SLEEP && sleep_in))
      |=> (wdt_count == '0) && !wdt_reset_out;
  endproperty
  a_off_modes: assert property (p_off_modes)
    else $error("watchdog counted while disabled");

  property p_always_on;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (watchdog_config_mode_in == MODE_ALWAYS_ON && tick && !clear_watchdog_instr_in
       && !osc_fail_in && !osc_startup_timer_in && !exit_hold && !sleep_rise && !sleep_fall
       && wdt_count != terminal)
      |=> (wdt_count == $past(wdt_count) + CNT_W'(1));
  endproperty
  a_always_on: assert property (p_always_on)
    else $error("always-on mode inactive");

  property p_ratio;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (period_select <= PS_MAX) |-> (terminal == (CNT_W'(32) << period_select) - CNT_W'(1));
  endproperty
  a_ratio: assert property (p_ratio)
    else $error("terminal count wrong for period select");

  property p_reserved;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (period_select > PS_MAX) |-> (terminal == CNT_W'(31));
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved code not at minimum ratio");

  property p_reset_ps;
    @(posedge mclk_in) disable iff (!rst_n_in)
      $rose(rst_n_in) |-> (period_select == PS_RESET) && !sw_watchdog_enable;
  endproperty
  a_reset_ps: assert property (p_reset_ps)
    else $error("period select not at reset value");

  property p_clear_pulse;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (clear_watchdog_instr_in || osc_fail_in || sleep_rise || sleep_fall)
      |=> (wdt_count == '0) && !wdt_reset_out && !wake_out;
  endproperty
  a_clear_pulse: assert property (p_clear_pulse)
    else $error("count not cleared by clear event");

  property p_ost_hold;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (sleep_fall && crystal_clock_in) ##1 osc_startup_timer_in [*2] |-> (wdt_count == '0);
  endproperty
  a_ost_hold: assert property (p_ost_hold)
    else $error("count moved during start-up hold");

  property p_sleep_timeout;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (timeout && sleep_in) |=> wake_out && !wdt_reset_out && sleep_entered_flag_out
                               && watchdog_expired_flag_out;
  endproperty
  a_sleep_timeout: assert property (p_sleep_timeout)
    else $error("sleep time-out did not wake");

  property p_awake_timeout;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (timeout && !sleep_in) |=> wdt_reset_out && !wake_out ##1 !wdt_reset_out;
  endproperty
  a_awake_timeout: assert property (p_awake_timeout)
    else $error("awake time-out did not give one reset pulse");

  property p_restart;
    @(posedge mclk_in) disable iff (!rst_n_in)
      timeout |=> (wdt_count == '0);
  endproperty
  a_restart: assert property (p_restart)
    else $error("count did not restart after time-out");

  property p_ctrl_read;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (rd_in && addr_in == OFF_CONTROL)
      |=> (rdata_out[7:6] == 2'h0) && (rdata_out[PS_MSB:PS_LSB] == $past(period_select));
  endproperty
  a_ctrl_read: assert property (p_ctrl_read)
    else $error("control read layout wrong");

  property p_tick_only;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (!tick && !clear_cond) |=> $stable(wdt_count);
  endproperty
  a_tick_only: assert property (p_tick_only)
    else $error("count moved without a time-base tick");
endmodule
`default_nettype wire

// [core/wtc_irq_bank.sv]
`timescale 1ns/10ps
`default_nettype none
module wtc_irq_bank #(
  parameter int N = 3
) (
  input  wire logic         mclk_in,
  input  wire logic         rst_n_in,
  input  wire logic [N-1:0] event_in,
  input  wire logic         enable_wr_in,
  input  wire logic         clear_wr_in,
  input  wire logic [N-1:0] wdata_in,
  output logic      [N-1:0] status_out,
  output logic      [N-1:0] enable_out,
  output logic              irq_out
);
  // a new event beats a clear in the same cycle
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      status_out <= '0;
    end else begin
      status_out <= (status_out & ~(clear_wr_in ? wdata_in : '0)) | event_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      enable_out <= '0;
    end else if (enable_wr_in) begin
      enable_out <= wdata_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(status_out & enable_out);
    end
  end
endmodule
`default_nettype wire

// [core/wtc_pkg.sv]
`default_nettype none
package wtc_pkg;
  // register port geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] OFF_CONTROL    = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR  = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_STATE      = 4'h4;
  // watchdog_control layout
  localparam int SWEN_BIT = 0;
  localparam int PS_LSB   = 1;
  localparam int PS_MSB   = 5;
  localparam int PS_W     = 5;
  localparam logic [PS_W-1:0] PS_RESET = 5'h0b;
  localparam logic [PS_W-1:0] PS_MAX   = 5'h12;
  localparam logic [PS_W-1:0] PS_BASE_SHIFT = 5'h05;
  localparam logic SWEN_RESET = 1'b0;
  // state register layout
  localparam int ST_EXPIRED = 0;
  localparam int ST_SLEPT   = 1;
  localparam int ST_ACTIVE  = 2;
  localparam int ST_HOLD    = 3;
  // interrupt events
  localparam int IRQ_N       = 3;
  localparam int IRQ_TIMEOUT = 0;
  localparam int IRQ_WAKE    = 1;
  localparam int IRQ_OSCFAIL = 2;
  // configuration mode codes
  localparam logic [1:0] MODE_ALWAYS_OFF = 2'h0;
  localparam logic [1:0] MODE_SOFTWARE   = 2'h1;
  localparam logic [1:0] MODE_OFF_SLEEP  = 2'h2;
  localparam logic [1:0] MODE_ALWAYS_ON  = 2'h3;
  // count width covers the largest ratio, 2^23
  localparam int CNT_W = 24;
  // time base: low-frequency rc clock against mclk
  localparam int CLK_PERIOD_PS = 4000;
  localparam int LF_RC_PERIOD_PS = 32258065;
  localparam int DIV_W = 14;
  localparam logic [DIV_W-1:0] TICK_CYCLES_DEF = DIV_W'(LF_RC_PERIOD_PS / CLK_PERIOD_PS);
endpackage
`default_nettype wire

// [core/wtc_tick_div.sv]
`timescale 1ns/10ps
`default_nettype none
module wtc_tick_div #(
  parameter int       DIV_W  = 14,
  parameter logic [13:0] CYCLES = 14'h1f80
) (
  input  wire logic mclk_in,
  input  wire logic rst_n_in,
  output logic      tick_out
);
  logic [DIV_W-1:0] div_cnt;

  // free running, so divider changes elsewhere never disturb it
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in || div_cnt == DIV_W'(CYCLES - 14'h0001)) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + DIV_W'(1);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      tick_out <= 1'b0;
    end else begin
      tick_out <= (div_cnt == DIV_W'(CYCLES - 14'h0001));
    end
  end
endmodule
`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import wtc_pkg::*;
  localparam logic [13:0] TICKS = 14'h0004;
  logic              mclk_in, rst_n_in, wr_in, rd_in, want_sleep, clr, osc_fail, osc_startup_timer, xtal;
  logic              sleep, rst_o, wake, exp_f, slp_f, irq;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, d;
  logic [1:0]        mode;
  logic [15:0]       n;
  int                n_mismatch, comparisons, n_rst, n_wake, cyc;
  // code -> cycles between time-outs with a 4-cycle tick
  logic [4:0]        codes [4] = '{5'h00, 5'h01, 5'h13, 5'h1f};
  logic [15:0]       per [4]   = '{16'h0080, 16'h0100, 16'h0080, 16'h0080};
  // mode, enable, sleep, reset seen, wake seen
  logic [5:0]        tab [8]   = '{6'h32, 6'h35, 6'h22, 6'h24, 6'h1a, 6'h1d, 6'h10, 6'h08};

  wtc_core #(.TICK_CYCLES(TICKS)) i_dut (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata), .watchdog_config_mode_in(mode),
    .sleep_in(sleep), .clear_watchdog_instr_in(clr), .osc_fail_in(osc_fail),
    .osc_startup_timer_in(osc_startup_timer), .crystal_clock_in(xtal), .wdt_reset_out(rst_o),
    .wake_out(wake), .watchdog_expired_flag_out(exp_f),
    .sleep_entered_flag_out(slp_f), .irq_out(irq)
  );
  wtc_cpu_model i_cpu (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .want_sleep_in(want_sleep),
    .wake_in(wake), .sleep_out(sleep)
  );

  initial begin
    mclk_in = 1'b0;
    forever #2 mclk_in = ~mclk_in;
  end

  always @(posedge mclk_in) begin
    cyc++;
    if (rst_o === 1'b1) n_rst++;
    if (wake === 1'b1) n_wake++;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done;
    end
  end

  task chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk_in);
    addr <= a;
    wdata <= v;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge mclk_in);
    addr <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1 d = rdata;
  endtask
  task cyc_wait(input int k);
    repeat (k) @(posedge mclk_in);
  endtask
  task pulse(input logic osc);
    @(posedge mclk_in);
    if (osc) osc_fail <= 1'b1;
    else clr <= 1'b1;
    @(posedge mclk_in);
    osc_fail <= 1'b0;
    clr <= 1'b0;
  endtask
  // bounded wait for a reset pulse or, with w set, a wake pulse
  task wait_ev(input logic w);
    n = 16'h0000;
    do begin
      @(posedge mclk_in);
      n++;
    end while (((w ? wake : rst_o) !== 1'b1) && n < 16'd2000);
  endtask
  task rst_cnt;
    #1 n_rst = 0;
    n_wake = 0;
  endtask
  task test_done;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    {rst_n_in, wr_in, rd_in, want_sleep, clr, osc_fail, osc_startup_timer, xtal} = 8'h00;
    addr = '0;
    wdata = '0;
    mode = MODE_ALWAYS_OFF;
    {n_mismatch, comparisons, n_rst, n_wake, cyc} = '0;
    repeat (2) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    rd(OFF_CONTROL);
    chk("control reset", d, 8'h16);
    wr(OFF_CONTROL, 8'hff);
    rd(OFF_CONTROL);
    chk("control bits", d, 8'h3f);
    // second reset in mid-run must restore the control register
    rst_n_in <= 1'b0;
    cyc_wait(2);
    rst_n_in <= 1'b1;
    rd(OFF_CONTROL);
    chk("control after reset", d, 8'h16);
    rd(4'hf);
    chk("unmapped read", d, 8'h00);
    $display("registers test done");
    mode <= MODE_ALWAYS_ON;
    foreach (codes[i]) begin
      wr(OFF_CONTROL, {2'b00, codes[i], 1'b0});
      pulse(1'b0);
      wait_ev(1'b0);
      wait_ev(1'b0);
      chk("period", n, per[i]);
    end
    $display("period test done");
    pulse(1'b0);
    rst_cnt;
    repeat (3) begin
      cyc_wait(100);
      pulse(1'b0);
      cyc_wait(100);
      pulse(1'b1);
    end
    chk("no reset while cleared", 16'(n_rst), 16'h0000);
    wait_ev(1'b0);
    cyc_wait(100);
    want_sleep <= 1'b1;
    wait_ev(1'b1);
    chk("sleep entry clears", 16'(n >= 16'd124), 16'h0001);
    cyc_wait(2);
    chk("wake flags", {exp_f, slp_f, sleep}, 16'h0006);
    rd(OFF_STATE);
    chk("state flags", d[1:0], 16'h0003);
    rd(OFF_IRQ_STATUS);
    chk("status events", d, 8'h07);
    want_sleep <= 1'b0;
    pulse(1'b0);
    cyc_wait(1);
    chk("flags cleared", {exp_f, slp_f}, 16'h0000);
    $display("sleep test done");
    foreach (tab[i]) begin
      mode <= tab[i][5:4];
      want_sleep <= tab[i][2];
      wr(OFF_CONTROL, {7'h00, tab[i][3]});
      pulse(1'b0);
      rst_cnt;
      cyc_wait(150);
      chk("mode events", {n_rst != 0, n_wake != 0}, tab[i][1:0]);
      want_sleep <= 1'b0;
      cyc_wait(2);
    end
    $display("mode test done");
    mode <= MODE_ALWAYS_ON;
    xtal <= 1'b1;
    osc_startup_timer <= 1'b1;
    want_sleep <= 1'b1;
    cyc_wait(50);
    want_sleep <= 1'b0;
    rst_cnt;
    cyc_wait(300);
    chk("start-up hold", 16'(n_rst + n_wake), 16'h0000);
    osc_startup_timer <= 1'b0;
    wait_ev(1'b0);
    chk("count after start-up", 16'(n <= 16'd140), 16'h0001);
    $display("start-up test done");
    mode <= MODE_ALWAYS_OFF;
    xtal <= 1'b0;
    wr(OFF_IRQ_CLEAR, 8'h07);
    rd(OFF_IRQ_STATUS);
    chk("status cleared", d, 8'h00);
    wr(OFF_IRQ_ENABLE, 8'h01);
    rd(OFF_IRQ_ENABLE);
    chk("irq enable", d, 8'h01);
    mode <= MODE_ALWAYS_ON;
    pulse(1'b0);
    wait_ev(1'b0);
    mode <= MODE_ALWAYS_OFF;
    cyc_wait(3);
    chk("irq raised", irq, 16'h0001);
    rd(OFF_IRQ_STATUS);
    chk("status time-out", d, 8'h01);
    wr(OFF_IRQ_ENABLE, 8'h00);
    cyc_wait(2);
    chk("irq masked", irq, 16'h0000);
    pulse(1'b1);
    wr(OFF_IRQ_ENABLE, 8'h04);
    cyc_wait(2);
    chk("irq osc fail", irq, 16'h0001);
    wr(OFF_IRQ_CLEAR, 8'h05);
    rd(OFF_IRQ_STATUS);
    chk("status after clear", d, 8'h00);
    chk("irq after clear", irq, 16'h0000);
    $display("interrupt test done");
    test_done;
  end
endmodule
`default_nettype wire

// [verif/wtc_cpu_model.sv]
`timescale 1ns/10ps
`default_nettype none
module wtc_cpu_model (
  input  wire logic mclk_in,
  input  wire logic rst_n_in,
  input  wire logic want_sleep_in,
  input  wire logic wake_in,
  output logic      sleep_out
);
  logic woke;
  // a wake drops sleep until the bench withdraws its request
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      woke      <= 1'b0;
      sleep_out <= 1'b0;
    end else begin
      if (wake_in)
        woke <= 1'b1;
      else if (!want_sleep_in)
        woke <= 1'b0;
      sleep_out <= want_sleep_in & ~woke & ~wake_in;
    end
  end
endmodule
`default_nettype wire
